// [rtl/irc_pkg.sv]
package irc_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_PORT_FN_A = 8'h00;
  localparam logic [7:0] OFF_PORT_FN_B = 8'h04;
  localparam logic [7:0] OFF_WAKE_FN = 8'h08;
  localparam logic [7:0] OFF_EDGE_SEL = 8'h0C;
  localparam logic [7:0] OFF_ENABLE_FIRST = 8'h10;
  localparam logic [7:0] OFF_ENABLE_SECOND = 8'h14;
  localparam logic [7:0] OFF_REQ_FIRST = 8'h18;
  localparam logic [7:0] OFF_REQ_SECOND = 8'h1C;
  localparam logic [7:0] OFF_WAKE_FLAGS = 8'h20;
  localparam logic [7:0] OFF_COND_CODE = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;

  // Field positions and widths.
  localparam int CCR_MASK_BIT = 7;
  localparam int WAKE_EN_BIT = 15;
  localparam int INT_FIRST_LSB = 5;
  localparam int INT_IN_FIRST = 10;

  // Source counts.
  localparam int N_EXT = 5;
  localparam int N_WAKE = 8;
  localparam int N_INT = 20;

  // Vector numbers.
  localparam logic [4:0] VEC_EXT_BASE = 5'h04;
  localparam logic [4:0] VEC_WAKE = 5'h09;
  localparam logic [4:0] VEC_INT_BASE = 5'h0A;

  // Exception entry step counts, in clock states; clear guard length in instructions.
  localparam logic [2:0] STACK_STATES = 3'h4;
  localparam logic [2:0] VECTOR_STATES = 3'h2;
  localparam logic [2:0] FETCH_STATES = 3'h4;
  localparam logic [2:0] INTERNAL_STATES = 3'h4;
  localparam logic [1:0] CLEAR_GUARD_INSTR = 2'h2;

  // Reset values.
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Software register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } irc_bus_req_t;

  // Memory request toward the core's bus during exception entry.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } irc_mem_req_t;

  // Exception entry sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STACK = 3'h1,
    ST_VECTOR = 3'h2,
    ST_FETCH = 3'h3,
    ST_INTERNAL = 3'h4,
    ST_LAUNCH = 3'h5
  } irc_state_t;

endpackage

// [rtl/irc_top.sv]
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Enabled wake pin falling edge sets flag.
// - Wake requests blocked while wake enable clear.
// - All wake sources share vector nine.
// - Edge select bit picks rising or falling.
// - Selected edge sets flag; enable gates request.
// - External pins vectors four to eight, pin0 first.
// - Twenty peripheral requests, vectors ten to twenty.
// - Highest priority pending taken, others wait.
// - Accept only while mask bit is zero.
// - Stack resume address and condition codes.
// - Acceptance sets the mask bit.
// - Fetch vector, start handler at its contents.
// - Flags clear only by writing zero.
// - Colliding request taken after clearing instruction.
// - Entry: wait, 4 stack, 2 vector, 8 more.
// - Stack word addresses force bit zero low.
// - Return loads only even byte into codes.
// - Function switch on low pin sets external flag: switch on for falling select, switch off for rising.
// - Wake function switch on low pin sets flag.
// - External and wake flag clear right after function write is ignored.
module irc_top (
  input wire logic CLK, // System clock, 250 MHz.
  input wire logic RESET_N, // Asynchronous reset, active low.
  input wire irc_pkg::irc_bus_req_t BUS, // Register port request.
  output logic [31:0] RDATA, // Read data, cycle after the read strobe.
  input wire logic [7:0] WAKE_PINS, // Wake pins, asynchronous.
  input wire logic [4:0] EXT_PINS, // External request pins, asynchronous.
  input wire logic [19:0] PERIPH_REQ, // Peripheral request pulses.
  input wire logic INSTR_END, // Core instruction boundary pulse.
  input wire logic [15:0] RESUME_PC, // Address of next instruction.
  input wire logic [15:0] STACK_PTR, // Current stack pointer.
  output irc_pkg::irc_mem_req_t MEM, // Stack write and vector read.
  input wire logic [15:0] MEM_RDATA, // Read data, cycle after MEM.rd.
  output logic HANDLER_GO, // Pulse: core starts at HANDLER_PC.
  output logic [15:0] HANDLER_PC, // Handler start address.
  output logic [15:0] STACK_PTR_NEW, // Stack pointer after stacking.
  output logic ENTRY_BUSY, // Exception entry in progress.
  input wire logic EXC_RETURN, // Exception return pulse.
  input wire logic [15:0] RETURN_CCR_WORD, // Stacked code word popped.
  output logic MASK_BIT // Global mask bit of the condition codes.
);

  // Clear-mask helper: software writes 0 to clear, hardware set wins.
  function automatic logic [19:0] flag_update(input logic [19:0] old_val,
                                              input logic [19:0] set_val,
                                              input logic clr_en,
                                              input logic [19:0] wdata);
    logic [19:0] res;
    res = old_val;
    if (clr_en) begin
      res = old_val & wdata;
    end
    flag_update = res | set_val;
  endfunction

  // Vector number of a peripheral source index.
  function automatic logic [4:0] int_vector(input int idx);
    int_vector = irc_pkg::VEC_INT_BASE + 5'((idx + 1) >> 1);
  endfunction

  // Register write and read hit helper.
  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] off);
    hit = strobe && (a == off);
  endfunction

  logic [7:0] wake_s1_reg;
  logic [7:0] wake_s2_reg;
  logic [7:0] wake_prev_reg;
  logic [4:0] ext_s1_reg;
  logic [4:0] ext_s2_reg;
  logic [4:0] ext_prev_reg;
  logic [7:0] port_fn_a_reg;
  logic [7:0] port_fn_b_reg;
  logic [7:0] wake_fn_reg;
  logic [7:0] wake_fn_prev_reg;
  logic [4:0] ext_fn_prev_reg;
  logic [4:0] edge_sel_reg;
  logic [4:0] ext_en_reg;
  logic wake_en_reg;
  logic [19:0] int_en_reg;
  logic [4:0] ext_flags_reg;
  logic [7:0] wake_flags_reg;
  logic [19:0] int_flags_reg;
  logic [7:0] ccr_reg;
  logic [1:0] guard_reg;
  logic [31:0] rdata_reg;
  irc_pkg::irc_state_t state_reg;
  irc_pkg::irc_state_t state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [4:0] vec_reg;
  logic [15:0] pc_save_reg;
  logic [15:0] sp_base_reg;
  logic [7:0] ccr_save_reg;
  logic [15:0] handler_pc_reg;
  irc_pkg::irc_mem_req_t mem_reg;
  irc_pkg::irc_mem_req_t mem_next;

  logic [4:0] ext_fn;
  logic [4:0] ext_rise;
  logic [4:0] ext_fall;
  logic [4:0] ext_set;
  logic [7:0] wake_set;
  logic clear_ok;
  logic [4:0] ext_pend;
  logic wake_pend;
  logic [19:0] int_pend;
  logic any_pend;
  logic [4:0] sel_vec;
  logic accept;

  // Two-stage synchronisers, then one edge stage; idle high, so no false edge.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_s1_reg <= 8'hFF;
      wake_s2_reg <= 8'hFF;
      wake_prev_reg <= 8'hFF;
      ext_s1_reg <= 5'h1F;
      ext_s2_reg <= 5'h1F;
      ext_prev_reg <= 5'h1F;
    end else begin
      wake_s1_reg <= WAKE_PINS;
      wake_s2_reg <= wake_s1_reg;
      wake_prev_reg <= wake_s2_reg;
      ext_s1_reg <= EXT_PINS;
      ext_s2_reg <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
    end
  end

  // Pin function bits: pins 1 to 3 in register a, pins 0 and 4 in b.
  assign ext_fn = {port_fn_b_reg[4], port_fn_a_reg[3:1], port_fn_b_reg[0]};

  // Edge detection and function switch events.
  assign ext_rise = ~ext_prev_reg & ext_s2_reg;
  assign ext_fall = ext_prev_reg & ~ext_s2_reg;
  assign ext_set = (ext_fn & ((edge_sel_reg & ext_rise) | (~edge_sel_reg & ext_fall)))
                 | (~ext_fn_prev_reg & ext_fn & ~ext_s2_reg & ~edge_sel_reg)
                 | (ext_fn_prev_reg & ~ext_fn & ~ext_s2_reg & edge_sel_reg);
  assign wake_set = (wake_fn_reg & wake_prev_reg & ~wake_s2_reg)
                  | (~wake_fn_prev_reg & wake_fn_reg & ~wake_s2_reg);

  // Configuration registers written by software.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port_fn_a_reg <= 8'h00;
      port_fn_b_reg <= 8'h00;
      wake_fn_reg <= 8'h00;
      edge_sel_reg <= 5'h00;
      ext_en_reg <= 5'h00;
      wake_en_reg <= 1'b0;
      int_en_reg <= 20'h0_0000;
    end else begin
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_PORT_FN_A)) begin
        port_fn_a_reg <= BUS.wdata[7:0];
      end
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_PORT_FN_B)) begin
        port_fn_b_reg <= BUS.wdata[7:0];
      end
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_WAKE_FN)) begin
        wake_fn_reg <= BUS.wdata[7:0];
      end
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_EDGE_SEL)) begin
        edge_sel_reg <= BUS.wdata[4:0];
      end
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_ENABLE_FIRST)) begin
        ext_en_reg <= BUS.wdata[4:0];
        int_en_reg[9:0] <= BUS.wdata[14:5];
        wake_en_reg <= BUS.wdata[irc_pkg::WAKE_EN_BIT];
      end
      if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_ENABLE_SECOND)) begin
        int_en_reg[19:10] <= BUS.wdata[9:0];
      end
    end
  end

  // Previous function bits, for switch detection.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_fn_prev_reg <= 5'h00;
      wake_fn_prev_reg <= 8'h00;
    end else begin
      ext_fn_prev_reg <= ext_fn;
      wake_fn_prev_reg <= wake_fn_reg;
    end
  end

  // Clear guard: a function write blocks external and wake flag clears until two instruction ends.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      guard_reg <= 2'h0;
    end else if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_PORT_FN_A) ||
                 hit(BUS.wr, BUS.addr, irc_pkg::OFF_PORT_FN_B) ||
                 hit(BUS.wr, BUS.addr, irc_pkg::OFF_WAKE_FN)) begin
      guard_reg <= irc_pkg::CLEAR_GUARD_INSTR;
    end else if (INSTR_END && guard_reg != 2'h0) begin
      guard_reg <= guard_reg - 2'h1;
    end
  end
  assign clear_ok = (guard_reg == 2'h0);

  // Request flags; flags are never cleared by acceptance.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_flags_reg <= 5'h00;
      wake_flags_reg <= 8'h00;
      int_flags_reg <= 20'h0_0000;
    end else begin
      ext_flags_reg <= 5'(flag_update(20'(ext_flags_reg), 20'(ext_set),
          hit(BUS.wr, BUS.addr, irc_pkg::OFF_REQ_FIRST) && clear_ok, 20'(BUS.wdata[4:0])));
      wake_flags_reg <= 8'(flag_update(20'(wake_flags_reg), 20'(wake_set),
          hit(BUS.wr, BUS.addr, irc_pkg::OFF_WAKE_FLAGS) && clear_ok, 20'(BUS.wdata[7:0])));
      int_flags_reg[9:0] <= 10'(flag_update(20'(int_flags_reg[9:0]), 20'(PERIPH_REQ[9:0]),
          hit(BUS.wr, BUS.addr, irc_pkg::OFF_REQ_FIRST), 20'(BUS.wdata[14:5])));
      int_flags_reg[19:10] <= 10'(flag_update(20'(int_flags_reg[19:10]),
          20'(PERIPH_REQ[19:10]),
          hit(BUS.wr, BUS.addr, irc_pkg::OFF_REQ_SECOND), 20'(BUS.wdata[9:0])));
    end
  end

  // Pending requests gated by their enables.
  assign ext_pend = ext_flags_reg & ext_en_reg;
  assign wake_pend = wake_en_reg && (wake_flags_reg != 8'h00);
  assign int_pend = int_flags_reg & int_en_reg;
  assign any_pend = (ext_pend != 5'h00) || wake_pend || (int_pend != 20'h0_0000);

  // Priority pick: external pins from pin 0 first, then wake, then peripherals.
  always_comb begin
    sel_vec = 5'h00;
    for (int i = irc_pkg::N_INT - 1; i >= 0; i--) begin
      if (int_pend[i]) begin
        sel_vec = int_vector(i);
      end
    end
    if (wake_pend) begin
      sel_vec = irc_pkg::VEC_WAKE;
    end
    for (int i = irc_pkg::N_EXT - 1; i >= 0; i--) begin
      if (ext_pend[i]) begin
        sel_vec = irc_pkg::VEC_EXT_BASE + 5'(i);
      end
    end
  end

  // Acceptance at an instruction boundary while unmasked.
  assign accept = (state_reg == irc_pkg::ST_IDLE) && INSTR_END && any_pend &&
                  !ccr_reg[irc_pkg::CCR_MASK_BIT];

  // Condition codes: acceptance masks, return reloads the even byte.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ccr_reg <= irc_pkg::CCR_RESET;
    end else if (accept) begin
      ccr_reg[irc_pkg::CCR_MASK_BIT] <= 1'b1;
    end else if (EXC_RETURN) begin
      ccr_reg <= RETURN_CCR_WORD[15:8];
    end else if (hit(BUS.wr, BUS.addr, irc_pkg::OFF_COND_CODE)) begin
      ccr_reg <= BUS.wdata[7:0];
    end
  end

  // Sequencer next state: stack, vector, fetch, internal, launch.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 3'h1;
    case (state_reg)
      irc_pkg::ST_IDLE: begin
        cnt_next = 3'h0;
        if (accept) begin
          state_next = irc_pkg::ST_STACK;
        end
      end
      irc_pkg::ST_STACK: begin
        if (cnt_reg == irc_pkg::STACK_STATES - 3'h1) begin
          state_next = irc_pkg::ST_VECTOR;
          cnt_next = 3'h0;
        end
      end
      irc_pkg::ST_VECTOR: begin
        if (cnt_reg == irc_pkg::VECTOR_STATES - 3'h1) begin
          state_next = irc_pkg::ST_FETCH;
          cnt_next = 3'h0;
        end
      end
      irc_pkg::ST_FETCH: begin
        if (cnt_reg == irc_pkg::FETCH_STATES - 3'h1) begin
          state_next = irc_pkg::ST_INTERNAL;
          cnt_next = 3'h0;
        end
      end
      irc_pkg::ST_INTERNAL: begin
        if (cnt_reg == irc_pkg::INTERNAL_STATES - 3'h1) begin
          state_next = irc_pkg::ST_LAUNCH;
          cnt_next = 3'h0;
        end
      end
      irc_pkg::ST_LAUNCH: begin
        state_next = irc_pkg::ST_IDLE;
        cnt_next = 3'h0;
      end
      default: begin
        state_next = irc_pkg::ST_IDLE;
        cnt_next = 3'h0;
      end
    endcase
  end

  // Memory request for the coming state, registered onto MEM.
  always_comb begin
    mem_next = '0;
    if (state_next == irc_pkg::ST_STACK && cnt_next == 3'h0) begin
      mem_next.wr = 1'b1;
      mem_next.addr = (accept ? {STACK_PTR[15:1], 1'b0} : sp_base_reg) - 16'h0002;
      mem_next.wdata = accept ? RESUME_PC : pc_save_reg;
    end else if (state_next == irc_pkg::ST_STACK && cnt_next == 3'h2) begin
      mem_next.wr = 1'b1;
      mem_next.addr = sp_base_reg - 16'h0004;
      mem_next.wdata = {ccr_save_reg, ccr_save_reg};
    end else if (state_next == irc_pkg::ST_VECTOR && cnt_next == 3'h0) begin
      mem_next.rd = 1'b1;
      mem_next.addr = {10'h000, vec_reg, 1'b0};
    end
  end

  // Sequencer registers and captured context.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= irc_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
      mem_reg <= '0;
      vec_reg <= 5'h00;
      pc_save_reg <= 16'h0000;
      sp_base_reg <= 16'h0000;
      ccr_save_reg <= 8'h00;
      handler_pc_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
      if (accept) begin
        vec_reg <= sel_vec;
        pc_save_reg <= RESUME_PC;
        sp_base_reg <= {STACK_PTR[15:1], 1'b0};
        ccr_save_reg <= ccr_reg;
      end
      if (state_reg == irc_pkg::ST_VECTOR && cnt_reg == 3'h1) begin
        handler_pc_reg <= MEM_RDATA;
      end
    end
  end

  // Register read port, data valid only in the cycle after the strobe.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= irc_pkg::REG_RESET;
    end else if (BUS.rd) begin
      case (BUS.addr)
        irc_pkg::OFF_PORT_FN_A: rdata_reg <= {24'h00_0000, port_fn_a_reg};
        irc_pkg::OFF_PORT_FN_B: rdata_reg <= {24'h00_0000, port_fn_b_reg};
        irc_pkg::OFF_WAKE_FN: rdata_reg <= {24'h00_0000, wake_fn_reg};
        irc_pkg::OFF_EDGE_SEL: rdata_reg <= {27'h000_0000, edge_sel_reg};
        irc_pkg::OFF_ENABLE_FIRST: begin
          rdata_reg <= {16'h0000, wake_en_reg, int_en_reg[9:0], ext_en_reg};
        end
        irc_pkg::OFF_ENABLE_SECOND: rdata_reg <= {22'h00_0000, int_en_reg[19:10]};
        irc_pkg::OFF_REQ_FIRST: begin
          rdata_reg <= {17'h0_0000, int_flags_reg[9:0], ext_flags_reg};
        end
        irc_pkg::OFF_REQ_SECOND: rdata_reg <= {22'h00_0000, int_flags_reg[19:10]};
        irc_pkg::OFF_WAKE_FLAGS: rdata_reg <= {24'h00_0000, wake_flags_reg};
        irc_pkg::OFF_COND_CODE: rdata_reg <= {24'h00_0000, ccr_reg};
        irc_pkg::OFF_STATUS: begin
          rdata_reg <= {20'h0_0000, any_pend, vec_reg, 3'h0, state_reg};
        end
        default: rdata_reg <= irc_pkg::REG_RESET;
      endcase
    end else begin
      rdata_reg <= irc_pkg::REG_RESET;
    end
  end

  // Outputs.
  assign RDATA = rdata_reg;
  assign MEM = mem_reg;
  assign HANDLER_GO = (state_reg == irc_pkg::ST_LAUNCH);
  assign HANDLER_PC = handler_pc_reg;
  assign STACK_PTR_NEW = sp_base_reg - 16'h0004;
  assign ENTRY_BUSY = (state_reg != irc_pkg::ST_IDLE);
  assign MASK_BIT = ccr_reg[irc_pkg::CCR_MASK_BIT];

endmodule

`default_nettype wire

// [testbench/irc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Core stand-in: an instruction boundary every third cycle and a vector table.
module irc_core_model (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Reset, active low.
  input wire irc_pkg::irc_mem_req_t mem_req, // Entry memory request.
  input wire logic handler_go, // Handler start pulse.
  output logic instr_end, // Instruction boundary pulse.
  output logic [15:0] resume_pc, // Resume address.
  output logic [15:0] stack_ptr, // Stack pointer, sometimes odd.
  output logic [15:0] mem_rdata // Vector word, valid after a read.
);
  logic [1:0] phase_reg;

  // Instruction boundary pulse every third cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 2'h0;
      instr_end <= 1'b0;
    end else begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      instr_end <= (phase_reg == 2'h2);
    end
  end

  // Moves pc and stack pointer after each entry, so odd pointers occur too.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resume_pc <= 16'h0400;
      stack_ptr <= 16'hFF01;
    end else if (handler_go) begin
      resume_pc <= resume_pc + 16'h0106;
      stack_ptr <= stack_ptr - 16'h0003;
    end
  end

  // Vector word is 8000 plus its address; stale data inverts every cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rdata <= 16'h0000;
    end else begin
      mem_rdata <= mem_req.rd ? (16'h8000 | mem_req.addr) : ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// [testbench/irc_top_props.sv]
`timescale 1ns/100ps
`default_nettype none

// Watches the exception entry and return at the top module's ports.
module irc_props (
  input wire logic CLK, // Clock.
  input wire logic RESET_N, // Reset, active low.
  input wire irc_pkg::irc_bus_req_t BUS, // Register port.
  input wire irc_pkg::irc_mem_req_t MEM, // Entry memory request.
  input wire logic [15:0] MEM_RDATA, // Vector word.
  input wire logic [15:0] STACK_PTR, // Stack pointer.
  input wire logic [15:0] RESUME_PC, // Resume address.
  input wire logic INSTR_END, // Instruction boundary.
  input wire logic ENTRY_BUSY, // Entry in progress.
  input wire logic HANDLER_GO, // Handler start.
  input wire logic [15:0] HANDLER_PC, // Handler address.
  input wire logic [15:0] STACK_PTR_NEW, // Pointer after stacking.
  input wire logic EXC_RETURN, // Return pulse.
  input wire logic [15:0] RETURN_CCR_WORD, // Popped code word.
  input wire logic MASK_BIT // Global mask bit.
);
  logic rd_d_reg;
  logic [15:0] vec_reg;
  logic ret_hi_reg;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Keeps the fetched vector word and the popped even byte's mask bit.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_d_reg <= 1'b0;
      vec_reg <= 16'h0000;
      ret_hi_reg <= 1'b0;
    end else begin
      rd_d_reg <= MEM.rd;
      if (rd_d_reg) vec_reg <= MEM_RDATA;
      ret_hi_reg <= RETURN_CCR_WORD[15];
    end
  end

  entry_masks_a: assert property ($rose(ENTRY_BUSY) |-> MASK_BIT)
    else $error("mask bit not set on acceptance");
  accept_unmasked_a: assert property ($rose(ENTRY_BUSY) |-> !$past(MASK_BIT))
    else $error("request accepted while masked");
  pc_stacked_a: assert property ($rose(ENTRY_BUSY) |-> MEM.wr
    && MEM.addr == (($past(STACK_PTR) & 16'hFFFE) - 16'h0002) && MEM.wdata == $past(RESUME_PC))
    else $error("resume address not stacked");
  codes_stacked_a: assert property ($rose(ENTRY_BUSY) |-> ##2 MEM.wr
    && MEM.addr == (($past(STACK_PTR, 3) & 16'hFFFE) - 16'h0004) && MEM.wdata[15:8] == MEM.wdata[7:0])
    else $error("code word not stacked");
  vector_read_a: assert property ($rose(ENTRY_BUSY) |-> ##4 MEM.rd && !MEM.addr[0]
    && MEM.addr >= 16'h0008 && MEM.addr <= 16'h0028)
    else $error("vector fetch wrong");
  entry_latency_a: assert property ($rose(ENTRY_BUSY) |-> !HANDLER_GO [*8] ##7 HANDLER_GO)
    else $error("handler start not at entry count");
  handler_addr_a: assert property (HANDLER_GO |-> HANDLER_PC == vec_reg)
    else $error("handler address differs from vector word");
  sp_after_a: assert property ($rose(ENTRY_BUSY) |-> ##14
    STACK_PTR_NEW == (($past(STACK_PTR, 15) & 16'hFFFE) - 16'h0004))
    else $error("stack pointer after stacking wrong");
  return_even_a: assert property (EXC_RETURN && !ENTRY_BUSY && !INSTR_END && !BUS.wr
    |=> MASK_BIT == ret_hi_reg)
    else $error("return did not load even byte");
endmodule

bind irc_top irc_props chk (.CLK(CLK), .RESET_N(RESET_N), .BUS(BUS), .MEM(MEM),
  .MEM_RDATA(MEM_RDATA), .STACK_PTR(STACK_PTR), .RESUME_PC(RESUME_PC), .INSTR_END(INSTR_END),
  .ENTRY_BUSY(ENTRY_BUSY), .HANDLER_GO(HANDLER_GO), .HANDLER_PC(HANDLER_PC),
  .STACK_PTR_NEW(STACK_PTR_NEW), .EXC_RETURN(EXC_RETURN),
  .RETURN_CCR_WORD(RETURN_CCR_WORD), .MASK_BIT(MASK_BIT));

`default_nettype wire

// [testbench/interrupt_request_controller_test.sv]
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench: pin and peripheral events, flags, entry and return.
module interrupt_request_controller_test;
  logic CLK, RESET_N, INSTR_END, HANDLER_GO, ENTRY_BUSY, EXC_RETURN, MASK_BIT;
  irc_pkg::irc_bus_req_t BUS;
  irc_pkg::irc_mem_req_t MEM;
  logic [31:0] RDATA;
  logic [7:0] WAKE_PINS;
  logic [4:0] EXT_PINS, pol;
  logic [19:0] PERIPH_REQ;
  logic [15:0] RESUME_PC, STACK_PTR, MEM_RDATA, HANDLER_PC, STACK_PTR_NEW, RETURN_CCR_WORD;
  logic [25:0] pend;
  int fails, checks, cycles, gos, i, j, s;

  irc_top dut (.CLK(CLK), .RESET_N(RESET_N), .BUS(BUS), .RDATA(RDATA), .WAKE_PINS(WAKE_PINS),
    .EXT_PINS(EXT_PINS), .PERIPH_REQ(PERIPH_REQ), .INSTR_END(INSTR_END), .RESUME_PC(RESUME_PC),
    .STACK_PTR(STACK_PTR), .MEM(MEM), .MEM_RDATA(MEM_RDATA), .HANDLER_GO(HANDLER_GO),
    .HANDLER_PC(HANDLER_PC), .STACK_PTR_NEW(STACK_PTR_NEW), .ENTRY_BUSY(ENTRY_BUSY),
    .EXC_RETURN(EXC_RETURN), .RETURN_CCR_WORD(RETURN_CCR_WORD), .MASK_BIT(MASK_BIT));
  irc_core_model core (.clk(CLK), .reset_n(RESET_N), .mem_req(MEM), .handler_go(HANDLER_GO),
    .instr_end(INSTR_END), .resume_pc(RESUME_PC), .stack_ptr(STACK_PTR), .mem_rdata(MEM_RDATA));

  // Clock at 250 MHz.
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // Counts handler starts and cuts a hung run short.
  always @(posedge CLK) begin
    cycles++;
    if (HANDLER_GO === 1'b1) gos++;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    BUS <= '{a, d, 1'b1, 1'b0};
    @(posedge CLK);
    BUS <= '0;
  endtask

  // Read data stands in the cycle after the strobe only.
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    BUS <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge CLK);
    BUS <= '0;
    #1;
    chk(name, exp, RDATA);
  endtask

  task automatic ret(input logic [15:0] w);
    @(posedge CLK);
    EXC_RETURN <= 1'b1;
    RETURN_CCR_WORD <= w;
    @(posedge CLK);
    EXC_RETURN <= 1'b0;
  endtask

  // Source code: 0..4 external pins, 5 wake, 6..25 peripherals 0..19.
  function automatic logic [15:0] handler_of(input int src);
    int v;
    v = (src < 5) ? 4 + src : (src == 5) ? 9 : 10 + ((src - 5) >> 1);
    return 16'h8000 | 16'(2 * v);
  endfunction

  // Unmasks, waits for each entry in priority order, then clears that flag.
  task automatic service();
    int n;
    while (pend != 26'h0) begin
      s = 0;
      while (!pend[s]) s++;
      ret(16'h00FF);
      n = 0;
      while (HANDLER_GO !== 1'b1 && n < 60) begin
        @(posedge CLK);
        #1;
        n++;
      end
      chk("handler address", {16'h0, handler_of(s)}, {16'h0, HANDLER_PC});
      chk("mask after entry", 32'h1, {31'h0, MASK_BIT});
      rd_chk("flags kept", irc_pkg::OFF_REQ_FIRST, {17'h0, pend[15:6], pend[4:0]});
      if (s == 5) wr(irc_pkg::OFF_WAKE_FLAGS, 32'h0);
      else if (s < 16) wr(irc_pkg::OFF_REQ_FIRST, ~(32'h1 << (s < 5 ? s : s - 1)));
      else wr(irc_pkg::OFF_REQ_SECOND, ~(32'h1 << (s - 16)));
      pend[s] = 1'b0;
    end
  endtask

  // Main sequence.
  initial begin
    fails = 0;
    checks = 0;
    cycles = 0;
    gos = 0;
    BUS = '0;
    WAKE_PINS = 8'hFF;
    EXT_PINS = 5'h1F;
    PERIPH_REQ = 20'h0;
    EXC_RETURN = 1'b0;
    RETURN_CCR_WORD = 16'h0000;
    RESET_N = 1'b0;
    void'($urandom(88));
    idle(6);
    RESET_N <= 1'b1;
    rd_chk("codes reset", irc_pkg::OFF_COND_CODE, 32'h80);
    rd_chk("unmapped", 8'h3C, 32'h0);
    $display("test reset done");
    pol = 5'($urandom);
    wr(irc_pkg::OFF_EDGE_SEL, {27'h0, pol});
    wr(irc_pkg::OFF_PORT_FN_A, 32'hE);
    wr(irc_pkg::OFF_PORT_FN_B, 32'h11);
    idle(12);
    for (i = 0; i < 5; i++) begin
      @(posedge CLK);
      EXT_PINS[i] <= 1'b0;
      idle(6);
      rd_chk("ext first edge", irc_pkg::OFF_REQ_FIRST, pol[i] ? 32'h0 : 32'h1 << i);
      @(posedge CLK);
      EXT_PINS[i] <= 1'b1;
      idle(6);
      rd_chk("ext second edge", irc_pkg::OFF_REQ_FIRST, 32'h1 << i);
      wr(irc_pkg::OFF_REQ_FIRST, 32'hFFFFFFFF);
      rd_chk("write one", irc_pkg::OFF_REQ_FIRST, 32'h1 << i);
      wr(irc_pkg::OFF_REQ_FIRST, ~(32'h1 << i));
      rd_chk("ext cleared", irc_pkg::OFF_REQ_FIRST, 32'h0);
    end
    wr(irc_pkg::OFF_PORT_FN_B, {27'h0, 1'b1, 3'h0, pol[0]});
    @(posedge CLK);
    EXT_PINS[0] <= 1'b0;
    idle(6);
    wr(irc_pkg::OFF_PORT_FN_B, {27'h0, 1'b1, 3'h0, ~pol[0]});
    idle(12);
    rd_chk("switch flag", irc_pkg::OFF_REQ_FIRST, 32'h1);
    @(posedge CLK);
    EXT_PINS[0] <= 1'b1;
    wr(irc_pkg::OFF_PORT_FN_B, 32'h11);
    idle(12);
    wr(irc_pkg::OFF_REQ_FIRST, 32'hFFFFFFFE);
    $display("test external pins done");
    wr(irc_pkg::OFF_WAKE_FN, 32'h7F);
    idle(10);
    j = $urandom_range(6, 0);
    @(posedge CLK);
    WAKE_PINS <= 8'h7F & ~(8'h1 << j);
    idle(6);
    rd_chk("wake edge", irc_pkg::OFF_WAKE_FLAGS, 32'h1 << j);
    wr(irc_pkg::OFF_WAKE_FN, 32'hFF);
    wr(irc_pkg::OFF_WAKE_FLAGS, 32'h0);
    idle(6);
    rd_chk("wake guard", irc_pkg::OFF_WAKE_FLAGS, (32'h1 << j) | 32'h80);
    @(posedge CLK);
    WAKE_PINS <= 8'hFF;
    idle(10);
    wr(irc_pkg::OFF_WAKE_FLAGS, 32'h0);
    rd_chk("wake clear", irc_pkg::OFF_WAKE_FLAGS, 32'h0);
    $display("test wake pins done");
    wr(irc_pkg::OFF_ENABLE_FIRST, 32'hFFFF);
    wr(irc_pkg::OFF_ENABLE_SECOND, 32'h3FF);
    for (int r = 0; r < 3; r++) begin
      pend = (r == 0) ? 26'h3FFFFFF : {20'($urandom & $urandom), 1'($urandom), 5'($urandom)};
      @(posedge CLK);
      EXT_PINS <= ~pend[4:0];
      WAKE_PINS <= {7'h7F, ~pend[5]};
      PERIPH_REQ <= pend[25:6];
      @(posedge CLK);
      PERIPH_REQ <= 20'h0;
      idle(3);
      EXT_PINS <= 5'h1F;
      WAKE_PINS <= 8'hFF;
      idle(8);
      #1;
      chk("no entry while masked", 32'h0, {31'h0, ENTRY_BUSY});
      rd_chk("second flags", irc_pkg::OFF_REQ_SECOND, {22'h0, pend[25:16]});
      service();
      $display("test acceptance round %0d done", r);
    end
    wr(irc_pkg::OFF_ENABLE_FIRST, 32'h7FFF);
    @(posedge CLK);
    WAKE_PINS <= 8'hFE;
    idle(6);
    WAKE_PINS <= 8'hFF;
    j = gos;
    ret(16'h00FF);
    idle(30);
    chk("wake disabled", j, gos);
    rd_chk("odd byte ignored", irc_pkg::OFF_COND_CODE, 32'h0);
    ret(16'h8000);
    rd_chk("mask restored", irc_pkg::OFF_COND_CODE, 32'h80);
    $display("test wake enable done");
    close_out();
  end
endmodule

`default_nettype wire
